// *** cmd_buffer_ram.sv ***
`timescale 1ns/100ps
// Command/response byte store with one write and two registered read ports
module cmd_buffer_ram #(
  parameter int AW = 6
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr_a,
  output logic [7:0] rd_data_a,
  input wire logic [AW-1:0] rd_addr_b,
  output logic [7:0] rd_data_b
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    rd_data_a <= mem[rd_addr_a];
    rd_data_b <= mem[rd_addr_b];
  end
endmodule : cmd_buffer_ram

// *** digest_extender.sv ***
`timescale 1ns/100ps
// Running digest over fed bytes, folded into the measurement on finish
module digest_extender (
  input wire logic clock,
  input wire logic rstn,
  input wire logic start,
  input wire logic feed_valid,
  input wire logic [7:0] feed_byte,
  input wire logic finish,
  output logic [31:0] measurement_ff
);
  logic [31:0] digest_ff;

  function automatic logic [31:0] mix(input logic [31:0] acc,
                                      input logic [31:0] val);
    logic [31:0] rot;
    rot = {acc[26:0], acc[31:27]};
    mix = (rot ^ val) + 32'h9e3779b9;
  endfunction : mix

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      digest_ff <= 32'h00000000;
    end else if (start) begin
      digest_ff <= 32'h00000000;
    end else if (feed_valid) begin
      digest_ff <= mix(digest_ff, {24'h000000, feed_byte});
    end
  end

  // Extend: new measurement depends on old measurement and digest
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      measurement_ff <= 32'h00000000;
    end else if (finish) begin
      measurement_ff <= mix(measurement_ff, digest_ff);
    end
  end
endmodule : digest_extender

// *** locality_access_gate.sv ***
// Functional notes
// [R1] Owning locality change during a running command aborts it.
// [R2] Owner reads buffer response bytes; owner writes fill the buffer.
// [R3] Non-owner: control and buffer read all-ones; writes and hash writes dropped.
// [R4] Hash start accepted by owner or when none owns; owner becomes 4.
// [R5] Owner hash-feed write consumes command buffer bytes as hash input.
// [R6] Owner hash-finish completes digest, extends measurement, releases locality.
// [R7] State/status read-only true values; control reads zero, any writer.
// [R8] Clock-run protocol optional; not supported here.
// [R9] Works with power-down input tied high.
// [R10] Only locality-tagged start code decoded; other cycles ignored.
// [R11] Locality cycles framed like I/O cycles: turnaround, sync, turnaround.
// [R12] Only the trusted host issues locality cycles.
// [R13] No-locality ranks below 0; requests and seizes from 0-4 honoured.
// [R14] Host splits wide writes into single-byte cycles.
// [R15] Write cycle: start 0101, type 0010.
// [R16] Write: four address nibbles, data low, data high, tar, sync, tar.
// [R17] Write answered with ready sync; data byte assembled low nibble first.
// [R18] Read: type 0000; byte returned low nibble first after sync.
`timescale 1ns/100ps
`include "locality_gate_map.svh"
module locality_access_gate #(
  parameter int BUF_AW = 6,
  parameter int EXEC_CYCLES = `EXEC_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic frame_n,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out_ff,
  output logic lad_oe_ff,
  input wire logic powerdown_n,
  output logic [2:0] owning_locality_ff,
  output logic cmd_busy_ff,
  output logic cmd_abort_ff,
  output logic [31:0] measurement_ff
);
  locality_gate_pkg::bus_state_t state_ff;
  locality_gate_pkg::bus_req_t req_ff;
  logic [1:0] cnt_ff;
  logic wr_strobe_ff;
  logic [7:0] intf_id_ff;
  logic [4:0] seized_ff;
  logic [2:0] prev_owner_ff;
  logic [15:0] exec_cnt_ff;
  logic [BUF_AW:0] fill_ff;
  logic feed_active_ff;
  logic [BUF_AW-1:0] feed_idx_ff;
  logic feed_valid_ff;
  logic hash_start_ff;
  logic hash_finish_ff;
  logic [7:0] rd_byte;
  logic [7:0] buf_rd_a;
  logic [7:0] buf_rd_b;
  logic [2:0] loc;
  logic [11:0] off;
  logic loc_valid;
  logic is_owner;
  logic buf_hit;
  logic buf_wr;
  logic feed_last;

  assign loc = req_ff.addr[`LOC_SEL_HI:`LOC_SEL_LO];
  assign off = req_ff.addr[`OFF_HI:`OFF_LO];
  assign loc_valid = (loc <= `LOC_MAX) && !req_ff.addr[15];
  assign is_owner = loc_valid && (owning_locality_ff == loc);
  assign buf_hit = (off >= `OFF_BUFFER) &&
                   (off < `OFF_BUFFER + 12'((1 << BUF_AW)));
  assign buf_wr = wr_strobe_ff && buf_hit && is_owner; // [R2] [R3]
  assign feed_last = feed_active_ff &&
                     ({1'b0, feed_idx_ff} == fill_ff - 1'b1);

  // Read data for the addressed register
  always_comb begin
    rd_byte = `FF_BYTE;
    if (!loc_valid) begin
      rd_byte = `FF_BYTE;
    end else if (off == `OFF_LOC_STATE) begin
      rd_byte = {3'h0, owning_locality_ff, 1'b0,
                 owning_locality_ff != `LOC_NONE}; // [R7]
    end else if (off == `OFF_LOC_CONTROL) begin
      rd_byte = 8'h00; // [R7]
    end else if (off == `OFF_LOC_STATUS) begin
      rd_byte = {6'h00, seized_ff[loc], is_owner}; // [R7]
    end else if (off == `OFF_INTF_ID) begin
      rd_byte = intf_id_ff;
    end else if (off == `OFF_BUF_CONTROL) begin
      rd_byte = is_owner ? {7'h00, cmd_busy_ff} : `FF_BYTE; // [R3]
    end else if (buf_hit) begin
      rd_byte = is_owner ? buf_rd_a : `FF_BYTE; // [R2] [R3]
    end
  end

  // Bus cycle sequencer; pd low parks it, pd tied high never intervenes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= locality_gate_pkg::ST_IDLE;
      cnt_ff <= 2'h0;
      req_ff <= '0;
      wr_strobe_ff <= 1'b0;
      lad_out_ff <= `TAR_DRIVE;
      lad_oe_ff <= 1'b0;
    end else begin
      wr_strobe_ff <= 1'b0;
      if (!powerdown_n) begin // [R9]
        state_ff <= locality_gate_pkg::ST_IDLE;
        lad_oe_ff <= 1'b0;
      end else if (!frame_n) begin
        lad_oe_ff <= 1'b0;
        cnt_ff <= 2'h0;
        if (lad_in == `START_LOCALITY) begin // [R10] [R15]
          state_ff <= locality_gate_pkg::ST_TYPE;
        end else begin
          state_ff <= locality_gate_pkg::ST_IDLE;
        end
      end else begin
        case (state_ff)
          locality_gate_pkg::ST_TYPE: begin
            if (lad_in == `TYPE_LOC_WRITE) begin // [R15]
              req_ff.is_write <= 1'b1;
              state_ff <= locality_gate_pkg::ST_ADDR;
            end else if (lad_in == `TYPE_LOC_READ) begin // [R18]
              req_ff.is_write <= 1'b0;
              state_ff <= locality_gate_pkg::ST_ADDR;
            end else begin
              state_ff <= locality_gate_pkg::ST_IDLE;
            end
          end
          locality_gate_pkg::ST_ADDR: begin
            req_ff.addr <= {req_ff.addr[11:0], lad_in}; // [R16]
            cnt_ff <= cnt_ff + 2'h1;
            if (cnt_ff == 2'h3) begin
              cnt_ff <= 2'h0;
              state_ff <= req_ff.is_write ? locality_gate_pkg::ST_WDATA :
                          locality_gate_pkg::ST_HTAR;
            end
          end
          locality_gate_pkg::ST_WDATA: begin
            cnt_ff <= cnt_ff + 2'h1;
            if (cnt_ff == 2'h0) begin
              req_ff.data[3:0] <= lad_in; // [R17]
            end else begin
              req_ff.data[7:4] <= lad_in; // [R17]
              cnt_ff <= 2'h0;
              state_ff <= locality_gate_pkg::ST_HTAR;
            end
          end
          locality_gate_pkg::ST_HTAR: begin
            cnt_ff <= cnt_ff + 2'h1;
            if (cnt_ff == 2'h1) begin // [R11]
              cnt_ff <= 2'h0;
              state_ff <= locality_gate_pkg::ST_SYNC;
              lad_out_ff <= `SYNC_READY; // [R17]
              lad_oe_ff <= 1'b1;
            end
          end
          locality_gate_pkg::ST_SYNC: begin
            if (req_ff.is_write) begin
              wr_strobe_ff <= 1'b1;
              state_ff <= locality_gate_pkg::ST_DTAR;
              lad_out_ff <= `TAR_DRIVE; // [R11]
            end else begin
              req_ff.data <= rd_byte;
              state_ff <= locality_gate_pkg::ST_RDATA;
              lad_out_ff <= rd_byte[3:0]; // [R18]
            end
          end
          locality_gate_pkg::ST_RDATA: begin
            state_ff <= locality_gate_pkg::ST_DTAR;
            lad_out_ff <= req_ff.data[7:4];
          end
          locality_gate_pkg::ST_DTAR: begin
            // Data nibble may itself be f, so count the turnaround cycle
            if (req_ff.is_write || cnt_ff == 2'h1) begin
              lad_oe_ff <= 1'b0;
              cnt_ff <= 2'h0;
              state_ff <= locality_gate_pkg::ST_IDLE;
            end else begin
              lad_out_ff <= `TAR_DRIVE; // [R11]
              cnt_ff <= 2'h1;
            end
          end
          default: begin
            lad_oe_ff <= 1'b0;
            state_ff <= locality_gate_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Ownership of the interface
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      owning_locality_ff <= `LOC_NONE;
      seized_ff <= 5'h00;
      hash_start_ff <= 1'b0;
      hash_finish_ff <= 1'b0;
    end else begin
      hash_start_ff <= 1'b0;
      hash_finish_ff <= 1'b0;
      if (wr_strobe_ff && loc_valid && off == `OFF_LOC_CONTROL) begin
        if (req_ff.data[`CTL_REQUEST] &&
            owning_locality_ff == `LOC_NONE) begin // [R13]
          owning_locality_ff <= loc;
          seized_ff[loc] <= 1'b0;
        end else if (req_ff.data[`CTL_SEIZE] &&
                     (owning_locality_ff == `LOC_NONE ||
                      loc > owning_locality_ff)) begin // [R13]
          if (owning_locality_ff != `LOC_NONE) begin
            seized_ff[owning_locality_ff] <= 1'b1;
          end
          owning_locality_ff <= loc;
          seized_ff[loc] <= 1'b0;
        end else if (req_ff.data[`CTL_RELINQUISH] && is_owner) begin
          owning_locality_ff <= `LOC_NONE;
        end else if (loc == `LOC_HASH && req_ff.data[`CTL_HASH_START] &&
                     (is_owner || owning_locality_ff == `LOC_NONE)) begin
          owning_locality_ff <= `LOC_HASH; // [R4]
          hash_start_ff <= 1'b1;
        end else if (loc == `LOC_HASH && is_owner &&
                     req_ff.data[`CTL_HASH_FINISH]) begin
          owning_locality_ff <= `LOC_NONE; // [R6]
          hash_finish_ff <= 1'b1;
        end
      end
    end
  end

  // Interface identity byte, writable from any locality
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      intf_id_ff <= `INTF_ID_RESET;
    end else if (wr_strobe_ff && loc_valid && off == `OFF_INTF_ID) begin
      intf_id_ff <= req_ff.data;
    end
  end

  // Command execution and abort on ownership change
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmd_busy_ff <= 1'b0;
      cmd_abort_ff <= 1'b0;
      exec_cnt_ff <= 16'h0000;
      prev_owner_ff <= `LOC_NONE;
    end else begin
      prev_owner_ff <= owning_locality_ff;
      cmd_abort_ff <= 1'b0;
      if (cmd_busy_ff && prev_owner_ff != owning_locality_ff) begin
        cmd_busy_ff <= 1'b0; // [R1]
        cmd_abort_ff <= 1'b1; // [R1]
      end else if (cmd_busy_ff) begin
        exec_cnt_ff <= exec_cnt_ff + 16'h0001;
        if (exec_cnt_ff == 16'(EXEC_CYCLES - 1)) begin
          cmd_busy_ff <= 1'b0;
        end
        if (wr_strobe_ff && is_owner && off == `OFF_BUF_CONTROL &&
            req_ff.data[`BCTL_CANCEL]) begin // [R3]
          cmd_busy_ff <= 1'b0;
          cmd_abort_ff <= 1'b1;
        end
      end else if (wr_strobe_ff && is_owner && off == `OFF_BUF_CONTROL &&
                   req_ff.data[`BCTL_START]) begin // [R3]
        cmd_busy_ff <= 1'b1;
        exec_cnt_ff <= 16'h0000;
      end
    end
  end

  // Buffer fill level and hash feed walk
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fill_ff <= '0;
      feed_active_ff <= 1'b0;
      feed_idx_ff <= '0;
      feed_valid_ff <= 1'b0;
    end else begin
      feed_valid_ff <= feed_active_ff;
      if (hash_finish_ff) begin
        feed_active_ff <= 1'b0;
      end else if (feed_active_ff) begin
        feed_idx_ff <= feed_idx_ff + 1'b1;
        if (feed_last) begin
          feed_active_ff <= 1'b0;
          fill_ff <= '0;
        end
      end else if (wr_strobe_ff && loc == `LOC_HASH && is_owner &&
                   off == `OFF_LOC_CONTROL &&
                   req_ff.data[`CTL_HASH_FEED] && fill_ff != '0) begin
        feed_active_ff <= 1'b1; // [R5]
        feed_idx_ff <= '0;
      end
      // A buffer write landing as the feed ends keeps its fill level
      if (buf_wr && ((feed_last && !hash_finish_ff) ||
                     {1'b0, off[BUF_AW-1:0]} >= fill_ff)) begin
        fill_ff <= {1'b0, off[BUF_AW-1:0]} + 1'b1;
      end
    end
  end

  cmd_buffer_ram #(
    .AW(BUF_AW)
  ) u_buffer (
    .clock(clock),
    .wr_en(buf_wr),
    .wr_addr(off[BUF_AW-1:0]),
    .wr_data(req_ff.data),
    .rd_addr_a(off[BUF_AW-1:0]),
    .rd_data_a(buf_rd_a),
    .rd_addr_b(feed_idx_ff),
    .rd_data_b(buf_rd_b)
  );

  digest_extender u_digest (
    .clock(clock),
    .rstn(rstn),
    .start(hash_start_ff),
    .feed_valid(feed_valid_ff), // [R5]
    .feed_byte(buf_rd_b),
    .finish(hash_finish_ff), // [R6]
    .measurement_ff(measurement_ff)
  );
endmodule : locality_access_gate

// *** locality_gate_chk_asserts.sv ***
`timescale 1ns/100ps
module locality_gate_chk #(
  parameter int EXEC_CYCLES = 100
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic frame_n,
  input wire logic [3:0] lad_in,
  input wire logic [3:0] lad_out_ff,
  input wire logic lad_oe_ff,
  input wire logic powerdown_n,
  input wire logic [2:0] owning_locality_ff,
  input wire logic cmd_busy_ff,
  input wire logic cmd_abort_ff,
  input wire logic [31:0] measurement_ff
);
  int busy_cnt;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= cmd_busy_ff ? busy_cnt + 1 : 0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sync_first_a: assert property (
    $rose(lad_oe_ff) |-> lad_out_ff == 4'h0)
    else $error("reply does not open with ready sync");
  tar_close_a: assert property (
    $fell(lad_oe_ff) |-> $past(lad_out_ff) == 4'hf)
    else $error("reply does not end with turnaround");
  reply_len_a: assert property (
    $rose(lad_oe_ff) |-> ##1 lad_oe_ff ##1
    ((!lad_oe_ff) or (lad_oe_ff [*2] ##1 !lad_oe_ff)))
    else $error("reply length wrong");
  reply_cause_a: assert property (
    $rose(lad_oe_ff) |->
    (!$past(frame_n, 8) && $past(lad_in, 8) == 4'h5) ||
    (!$past(frame_n, 10) && $past(lad_in, 10) == 4'h5))
    else $error("reply without locality start");
  frame_quiet_a: assert property (
    !frame_n |-> !lad_oe_ff)
    else $error("device drives during start");
  owner_range_a: assert property (
    owning_locality_ff <= 3'h4 || owning_locality_ff == 3'h7)
    else $error("owner out of range");
  abort_follow_a: assert property (
    $changed(owning_locality_ff) && cmd_busy_ff |=> cmd_abort_ff)
    else $error("owner change did not abort");
  abort_idle_a: assert property (
    $rose(cmd_abort_ff) |-> ##[0:1] !cmd_busy_ff)
    else $error("command still busy after abort");
  busy_len_a: assert property (
    busy_cnt <= EXEC_CYCLES + 1)
    else $error("command runs too long");
  park_a: assert property (
    !powerdown_n |=> !lad_oe_ff)
    else $error("device drives in power-down");
  cover property ($rose(lad_oe_ff));
  cover property ($rose(cmd_abort_ff));
  cover property (owning_locality_ff == 3'h4);
endmodule : locality_gate_chk

bind locality_access_gate locality_gate_chk #(
  .EXEC_CYCLES(EXEC_CYCLES)
) locality_gate_chk_i (
  .clock(clock), .rstn(rstn), .frame_n(frame_n), .lad_in(lad_in),
  .lad_out_ff(lad_out_ff), .lad_oe_ff(lad_oe_ff),
  .powerdown_n(powerdown_n), .owning_locality_ff(owning_locality_ff),
  .cmd_busy_ff(cmd_busy_ff), .cmd_abort_ff(cmd_abort_ff),
  .measurement_ff(measurement_ff)
);

// *** locality_gate_map.svh ***
`ifndef LOCALITY_GATE_MAP_SVH
`define LOCALITY_GATE_MAP_SVH

// Locality-tagged bus cycle codes
`define START_LOCALITY 4'h5
`define TYPE_LOC_WRITE 4'h2
`define TYPE_LOC_READ 4'h0
`define SYNC_READY 4'h0
`define TAR_DRIVE 4'hf

// Address fields: locality select and register offset
`define LOC_SEL_HI 14
`define LOC_SEL_LO 12
`define OFF_HI 11
`define OFF_LO 0
`define LOC_NONE 3'h7
`define LOC_HASH 3'h4
`define LOC_MAX 3'h4

// Register offsets inside one locality window
`define OFF_LOC_STATE 12'h000
`define OFF_LOC_CONTROL 12'h008
`define OFF_LOC_STATUS 12'h00c
`define OFF_INTF_ID 12'h030
`define OFF_BUF_CONTROL 12'h040
`define OFF_BUFFER 12'h080

// Locality control write bits
`define CTL_REQUEST 0
`define CTL_RELINQUISH 1
`define CTL_SEIZE 2
`define CTL_HASH_START 4
`define CTL_HASH_FEED 5
`define CTL_HASH_FINISH 6

// Buffer control bits
`define BCTL_START 0
`define BCTL_CANCEL 1

// Reset value and all-ones read byte
`define INTF_ID_RESET 8'h00
`define FF_BYTE 8'hff

// Command execution time
`define EXEC_TIME_NS 800
`define CLK_PERIOD_NS 8
`define EXEC_CYCLES (`EXEC_TIME_NS / `CLK_PERIOD_NS)

`endif

// *** locality_gate_pkg.sv ***
package locality_gate_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TYPE = 3'b001,
    ST_ADDR = 3'b011,
    ST_WDATA = 3'b010,
    ST_HTAR = 3'b110,
    ST_SYNC = 3'b111,
    ST_RDATA = 3'b101,
    ST_DTAR = 3'b100
  } bus_state_t;

  typedef struct packed {
    logic is_write;
    logic [15:0] addr;
    logic [7:0] data;
  } bus_req_t;

endpackage : locality_gate_pkg

// *** lpc_host_model.sv ***
`timescale 1ns/100ps
module lpc_host_model (
  input wire logic clock,
  input wire logic dev_oe,
  output logic frame_n,
  output logic [3:0] host_lad
);
  initial begin
    frame_n = 1'b1;
    host_lad = 4'hf;
  end
  // One single-byte cycle; ok stays low if the device never replies
  task automatic cycle(input logic [3:0] start, input logic wr,
    input logic [15:0] addr, input logic [7:0] data, output logic ok);
    int k;
    ok = 1'b0;
    @(posedge clock);
    frame_n <= 1'b0;
    host_lad <= start;
    @(posedge clock);
    frame_n <= 1'b1;
    host_lad <= wr ? 4'h2 : 4'h0;
    for (k = 3; k >= 0; k--) begin
      @(posedge clock);
      host_lad <= addr[k*4 +: 4];
    end
    if (wr) begin
      @(posedge clock);
      host_lad <= data[3:0];
      @(posedge clock);
      host_lad <= data[7:4];
    end
    @(posedge clock);
    host_lad <= 4'hf;
    for (k = 0; k < 20 && !ok; k++) begin
      @(posedge clock);
      ok = dev_oe;
    end
    for (k = 0; k < 8 && dev_oe; k++) begin
      @(posedge clock);
    end
  endtask : cycle
endmodule : lpc_host_model

// *** tb_locality_access_gate.sv ***
`timescale 1ns/100ps
module tb_locality_access_gate;
  logic clock, rstn, powerdown_n, frame_n, ok;
  logic [3:0] host_lad, lad_in, lad_out_ff, nib[4];
  logic lad_oe_ff, cmd_busy_ff, cmd_abort_ff;
  logic [2:0] owning_locality_ff;
  logic [31:0] measurement_ff;
  logic [7:0] exp_q[$];
  logic [7:0] b[4];
  int mismatches, n_compared, n_abort, n_nib, seed, k;
  // Released bus carries the host model's drive level
  assign lad_in = lad_oe_ff ? lad_out_ff : host_lad;
  locality_access_gate #(.EXEC_CYCLES(40)) locality_access_gate_i (
    .clock(clock), .rstn(rstn), .frame_n(frame_n), .lad_in(lad_in),
    .lad_out_ff(lad_out_ff), .lad_oe_ff(lad_oe_ff),
    .powerdown_n(powerdown_n), .owning_locality_ff(owning_locality_ff),
    .cmd_busy_ff(cmd_busy_ff), .cmd_abort_ff(cmd_abort_ff),
    .measurement_ff(measurement_ff)
  );
  lpc_host_model lpc_host_model_i (
    .clock(clock), .dev_oe(lad_oe_ff), .frame_n(frame_n),
    .host_lad(host_lad)
  );
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic wr(input logic [2:0] loc, input logic [11:0] off,
    input logic [7:0] d);
    lpc_host_model_i.cycle(4'h5, 1'b1, {1'b0, loc, off}, d, ok);
    check(ok, 1'b1);
    if (ok !== 1'b1) end_sim();
  endtask : wr
  task automatic rd(input logic [2:0] loc, input logic [11:0] off,
    input logic [7:0] e);
    exp_q.push_back(e);
    lpc_host_model_i.cycle(4'h5, 1'b0, {1'b0, loc, off}, 8'h00, ok);
    check(ok, 1'b1);
    if (ok !== 1'b1) end_sim();
  endtask : rd
  // Collects each reply and compares read bytes with the oldest note
  always @(posedge clock) begin
    if (cmd_abort_ff === 1'b1) n_abort++;
    if (lad_oe_ff === 1'b1) begin
      if (n_nib < 4) nib[n_nib] = lad_out_ff;
      n_nib++;
    end else if (n_nib != 0) begin
      if (n_nib == 4 && exp_q.size() > 0) begin
        check({nib[2], nib[1]}, exp_q.pop_front());
      end else if (n_nib != 2) begin
        check(n_nib, 2);
      end
      n_nib = 0;
    end
  end
  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    end_sim();
  end
  initial begin
    rstn = 1'b0;
    powerdown_n = 1'b1;
    seed = 32'h65f2f4aa;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    check(owning_locality_ff, 3'h7);
    rd(3'h0, 12'h080, 8'hff);
    rd(3'h1, 12'h040, 8'hff);
    rd(3'h0, 12'h008, 8'h00);
    wr(3'h2, 12'h008, 8'h01);
    check(owning_locality_ff, 3'h2);
    rd(3'h2, 12'h00c, 8'h01);
    rd(3'h1, 12'h00c, 8'h00);
    rd(3'h3, 12'h000, 8'h09);
    for (k = 0; k < 4; k++) begin
      b[k] = 8'($random(seed));
      wr(3'h2, 12'h080 + 12'(k), b[k]);
    end
    wr(3'h1, 12'h080, ~b[0]);
    for (k = 0; k < 4; k++) rd(3'h2, 12'h080 + 12'(k), b[k]);
    rd(3'h1, 12'h081, 8'hff);
    rd(3'h2, 12'h040, 8'h00);
    wr(3'h2, 12'h040, 8'h01);
    check(cmd_busy_ff, 1'b1);
    rd(3'h2, 12'h040, 8'h01);
    wr(3'h2, 12'h008, 8'h02);
    repeat (4) @(posedge clock);
    check(n_abort, 1);
    check(cmd_busy_ff, 1'b0);
    wr(3'h0, 12'h008, 8'h01);
    wr(3'h4, 12'h008, 8'h10);
    check(owning_locality_ff, 3'h0);
    wr(3'h0, 12'h008, 8'h02);
    wr(3'h3, 12'h008, 8'h40);
    check(measurement_ff, 32'h0);
    wr(3'h4, 12'h008, 8'h10);
    check(owning_locality_ff, 3'h4);
    wr(3'h4, 12'h080, 8'($random(seed)));
    wr(3'h4, 12'h008, 8'h20);
    wr(3'h1, 12'h008, 8'h40);
    check(owning_locality_ff, 3'h4);
    wr(3'h4, 12'h008, 8'h40);
    for (k = 0; k < 60 && owning_locality_ff !== 3'h7; k++) begin
      @(posedge clock);
    end
    repeat (2) @(posedge clock);
    check(owning_locality_ff, 3'h7);
    check(measurement_ff != 32'h0, 1'b1);
    lpc_host_model_i.cycle(4'h0, 1'b1, 16'h0008, 8'h01, ok);
    check(ok, 1'b0);
    check(owning_locality_ff, 3'h7);
    powerdown_n <= 1'b0;
    repeat (3) @(posedge clock);
    powerdown_n <= 1'b1;
    @(posedge clock);
    wr(3'h1, 12'h008, 8'h01);
    check(owning_locality_ff, 3'h1);
    wr(3'h3, 12'h008, 8'h04);
    check(owning_locality_ff, 3'h3);
    rd(3'h1, 12'h00c, 8'h02);
    wr(3'h3, 12'h040, 8'h01);
    check(cmd_busy_ff, 1'b1);
    wr(3'h3, 12'h040, 8'h02);
    repeat (2) @(posedge clock);
    check(n_abort, 2);
    check(cmd_busy_ff, 1'b0);
    repeat (2) @(posedge clock);
    check(exp_q.size(), 0);
    end_sim();
  end
endmodule : tb_locality_access_gate
